// ===== rtl/smt_consts.svh
// constants of the secure memory two-wire target
//
// Summary of operation
// - Data line holds steady while clock high, except framing conditions.
// - Any data change while clock high is taken as start or stop.
// - Falling data with clock high is a start; commands only follow one.
// - Rising data with clock high is a stop; it ends the transfer.
// - Stop after a read sequence puts the device into standby.
// - Every address and data item moves as an 8-bit word, one bit per clock.
// - Device pulls data low in the ninth clock to acknowledge each word it accepts.
// - Self-timed write cycle ends within 5 ms of the stop ending a write.
// - User memory is eight zones of 128 bytes, offsets 0x00 to 0x7f.
// - A zone is refused unless its configured security rights are met.
// - Adjacent zones with the same group setting are reachable as one larger zone.
// - Every user zone access is checked against the rights of the zone named in its command.
// - Written bits sampled on clock rise, read bits driven on clock fall.
// - No reset pin and no answer-to-reset in synchronous mode.
// - Device only pulls the data line low, never drives it high.
`ifndef SMT_CONSTS_SVH
`define SMT_CONSTS_SVH

`define SMT_CLK_MHZ 25
`define SMT_TWR_US 5000
`define SMT_TWR_CYC (`SMT_TWR_US * `SMT_CLK_MHZ)
`define SMT_BIT_LAST 4'h8
`define SMT_BIT_PRE 4'h7
`define SMT_CMD_CODE 4'hb
`define SMT_OFF_LAST 7'h7f
`define SMT_ZONE_LAST 3'h7
`define SMT_FIFO_DEPTH 4
`define SMT_BYTE_CMD 2'h0
`define SMT_BYTE_ADDR 2'h1
`define SMT_BYTE_DATA 2'h2

`endif

// ===== rtl/smt_pkg.sv
// types of the secure memory two-wire target
package smt_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK = 6'h04,
    ST_TX = 6'h08,
    ST_HACK = 6'h10,
    ST_WAIT = 6'h20
  } smt_state_t;

  typedef struct packed {
    logic [3:0] code;
    logic [2:0] zone;
    logic rd;
  } smt_cmd_t;

  typedef struct packed {
    logic [2:0] zone;
    logic [6:0] off;
  } smt_addr_t;

  typedef struct packed {
    smt_addr_t addr;
    logic [7:0] data;
  } smt_wr_t;
endpackage : smt_pkg

// ===== rtl/smt_fifo.sv
// small valid/ready fifo
`timescale 1ns/1ns
module smt_fifo #(
  parameter int W = 18,
  parameter int D = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [W-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [W-1:0] out_data_out
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] mem [0:D-1];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic push, pop;

  assign in_ready_out = (cnt_r != (AW+1)'(D));
  assign out_valid_out = (cnt_r != '0);
  assign out_data_out = mem[rp_r];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    if (push) begin
      wp_nxt = (wp_r == AW'(D - 1)) ? '0 : AW'(wp_r + 1'b1);
    end
    if (pop) begin
      rp_nxt = (rp_r == AW'(D - 1)) ? '0 : AW'(rp_r + 1'b1);
    end
    cnt_nxt = (AW+1)'(cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem[wp_r] <= in_data_in;
    end
  end
endmodule : smt_fifo

// ===== rtl/smt_zone_store.sv
// user zone memory with access control and zone chaining
`timescale 1ns/1ns
`include "smt_consts.svh"
module smt_zone_store (
  input wire logic clk_in,
  input wire logic wr_valid_in,
  input wire smt_pkg::smt_wr_t wr_in,
  input wire smt_pkg::smt_addr_t cur_in,
  output logic [7:0] rd_data_out,
  output smt_pkg::smt_addr_t next_out,
  input wire logic [2:0] chk_zone_in,
  output logic chk_rd_ok_out,
  output logic chk_wr_ok_out,
  input wire logic [7:0] zone_rd_en_in,
  input wire logic [7:0] zone_wr_en_in,
  input wire logic [7:0][2:0] zone_grp_in
);
  import smt_pkg::*;
  logic [7:0] mem [0:1023];
  logic [2:0] nz;

  assign chk_rd_ok_out = zone_rd_en_in[chk_zone_in];
  assign chk_wr_ok_out = zone_wr_en_in[chk_zone_in];
  assign rd_data_out = mem[cur_in];
  assign nz = 3'(cur_in.zone + 1'b1);

  // chain into next zone of same group
  always_comb begin
    next_out = cur_in;
    if (cur_in.off != `SMT_OFF_LAST) begin
      next_out.off = 7'(cur_in.off + 1'b1);
    end else begin
      next_out.off = 7'h00;
      if (cur_in.zone != `SMT_ZONE_LAST && zone_grp_in[nz] == zone_grp_in[cur_in.zone]) begin
        next_out.zone = nz;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr_valid_in) begin
      mem[wr_in.addr] <= wr_in.data;
    end
  end
endmodule : smt_zone_store

// ===== rtl/smt_target.sv
// two-wire serial target front end of the secure memory
`timescale 1ns/1ns
`include "smt_consts.svh"
module smt_target #(
  parameter int WR_CYCLES = `SMT_TWR_CYC
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic [7:0] zone_rd_en_in,
  input wire logic [7:0] zone_wr_en_in,
  input wire logic [7:0][2:0] zone_grp_in,
  output logic sda_out,
  output logic sda_oe_out,
  output logic busy_out,
  output logic standby_out
);
  import smt_pkg::*;
  localparam int TMR_W = $clog2(WR_CYCLES + 1);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic scl_m_r, scl_s_r, scl_p_r, sda_m_r, sda_s_r, sda_p_r;
  logic scl_rise, scl_fall, start, stop;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_p_r <= 1'b1;
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_p_r <= 1'b1;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_p_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_p_r <= sda_s_r;
    end
  end

  assign scl_rise = scl_s_r & ~scl_p_r;
  assign scl_fall = ~scl_s_r & scl_p_r;
  // data change with clock high is framing
  assign start = scl_s_r & scl_p_r & sda_p_r & ~sda_s_r;
  assign stop = scl_s_r & scl_p_r & ~sda_p_r & sda_s_r;

  // ----------------------------------------
  // write buffer and zone store
  // ----------------------------------------
  smt_wr_t push_word, drain_word;
  logic push, fifo_rdy, drain_vld;
  logic [7:0] rd_data;
  smt_addr_t addr_r, addr_nxt, next_addr;
  logic chk_rd_ok, chk_wr_ok;
  smt_cmd_t cmd_in;
  logic busy_r, busy_nxt;
  logic [7:0] sh_r, sh_nxt;

  assign push_word.addr = addr_r;
  assign push_word.data = {sh_r[6:0], sda_s_r};
  assign cmd_in = smt_cmd_t'({sh_r[6:0], sda_s_r});

  smt_fifo #(.W($bits(smt_wr_t)), .D(`SMT_FIFO_DEPTH)) u_fifo (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .in_valid_in(push),
    .in_ready_out(fifo_rdy),
    .in_data_in(push_word),
    .out_valid_out(drain_vld),
    .out_ready_in(busy_r),
    .out_data_out(drain_word)
  );

  smt_zone_store u_store (
    .clk_in(clk_in),
    .wr_valid_in(drain_vld & busy_r),
    .wr_in(drain_word),
    .cur_in(addr_r),
    .rd_data_out(rd_data),
    .next_out(next_addr),
    .chk_zone_in(cmd_in.zone),
    .chk_rd_ok_out(chk_rd_ok),
    .chk_wr_ok_out(chk_wr_ok),
    .zone_rd_en_in(zone_rd_en_in),
    .zone_wr_en_in(zone_wr_en_in),
    .zone_grp_in(zone_grp_in)
  );

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  smt_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [1:0] byte_r, byte_nxt;
  logic rd_r, rd_nxt, ack_r, ack_nxt, oe_r, oe_nxt;
  logic pend_r, pend_nxt, stby_r, stby_nxt;
  logic [TMR_W-1:0] tmr_r, tmr_nxt;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    byte_nxt = byte_r;
    rd_nxt = rd_r;
    addr_nxt = addr_r;
    ack_nxt = ack_r;
    oe_nxt = oe_r;
    pend_nxt = pend_r;
    stby_nxt = stby_r;
    busy_nxt = busy_r;
    tmr_nxt = tmr_r;
    push = 1'b0;
    if (busy_r) begin
      if (tmr_r == '0) begin
        busy_nxt = 1'b0;
      end else begin
        tmr_nxt = TMR_W'(tmr_r - 1'b1);
      end
    end
    if (start) begin
      st_nxt = ST_RX;
      cnt_nxt = 4'h0;
      byte_nxt = `SMT_BYTE_CMD;
      oe_nxt = 1'b0;
      rd_nxt = 1'b0;
      stby_nxt = 1'b0;
    end else if (stop) begin
      st_nxt = ST_IDLE;
      oe_nxt = 1'b0;
      if (rd_r) begin
        stby_nxt = 1'b1;
      end
      if (pend_r) begin
        pend_nxt = 1'b0;
        busy_nxt = 1'b1;
        tmr_nxt = TMR_W'(WR_CYCLES - 1);
      end
    end else begin
      unique case (st_r)
        ST_IDLE: begin
        end
        ST_RX: begin
          // data taken at clock rise only
          if (scl_rise && cnt_r != `SMT_BIT_LAST) begin
            sh_nxt = {sh_r[6:0], sda_s_r};
            cnt_nxt = 4'(cnt_r + 1'b1);
            if (cnt_r == `SMT_BIT_PRE) begin
              unique case (byte_r)
                `SMT_BYTE_CMD: begin
                  ack_nxt = (cmd_in.code == `SMT_CMD_CODE) && !busy_r &&
                            (cmd_in.rd ? chk_rd_ok : chk_wr_ok);
                  rd_nxt = cmd_in.rd;
                  addr_nxt.zone = cmd_in.zone;
                end
                `SMT_BYTE_ADDR: begin
                  ack_nxt = 1'b1;
                  addr_nxt.off = push_word.data[6:0];
                end
                default: begin
                  ack_nxt = fifo_rdy;
                  push = fifo_rdy;
                  if (fifo_rdy) begin
                    pend_nxt = 1'b1;
                    addr_nxt = next_addr;
                  end
                end
              endcase
            end
          end else if (scl_fall && cnt_r == `SMT_BIT_LAST) begin
            // pull low through the ninth clock
            st_nxt = ST_ACK;
            oe_nxt = ack_r;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            cnt_nxt = 4'h0;
            if (!ack_r) begin
              st_nxt = ST_IDLE;
            end else if (rd_r && byte_r != `SMT_BYTE_CMD) begin
              st_nxt = ST_TX;
              sh_nxt = rd_data;
              oe_nxt = ~rd_data[7];
            end else begin
              st_nxt = ST_RX;
              if (byte_r != `SMT_BYTE_DATA) begin
                byte_nxt = 2'(byte_r + 1'b1);
              end
            end
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_nxt = 4'(cnt_r + 1'b1);
          end else if (scl_fall) begin
            if (cnt_r == `SMT_BIT_LAST) begin
              oe_nxt = 1'b0;
              st_nxt = ST_HACK;
            end else begin
              sh_nxt = {sh_r[6:0], 1'b0};
              oe_nxt = ~sh_r[6];
            end
          end
        end
        ST_HACK: begin
          if (scl_rise) begin
            if (!sda_s_r) begin
              addr_nxt = next_addr;
              st_nxt = ST_WAIT;
            end else begin
              st_nxt = ST_IDLE;
            end
          end
        end
        ST_WAIT: begin
          if (scl_fall) begin
            st_nxt = ST_TX;
            cnt_nxt = 4'h0;
            sh_nxt = rd_data;
            oe_nxt = ~rd_data[7];
          end
        end
      endcase
    end
  end

  // no reset pin, idle line stays released
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      byte_r <= 2'h0;
      rd_r <= 1'b0;
      addr_r <= '0;
      ack_r <= 1'b0;
      oe_r <= 1'b0;
      pend_r <= 1'b0;
      stby_r <= 1'b0;
      busy_r <= 1'b0;
      tmr_r <= '0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      byte_r <= byte_nxt;
      rd_r <= rd_nxt;
      addr_r <= addr_nxt;
      ack_r <= ack_nxt;
      oe_r <= oe_nxt;
      pend_r <= pend_nxt;
      stby_r <= stby_nxt;
      busy_r <= busy_nxt;
      tmr_r <= tmr_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe_out = oe_r;
  assign busy_out = busy_r;
  assign standby_out = stby_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [TMR_W:0] blen_r;
  always_ff @(posedge clk_in) begin
    if (rst_in || !busy_r) begin
      blen_r <= '0;
    end else begin
      blen_r <= (TMR_W+1)'(blen_r + 1'b1);
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  chk_start_restart: assert property (start |=> st_r == ST_RX && cnt_r == 4'h0)
    else $error("start did not restart command receive");
  chk_stop_idle: assert property (stop |=> st_r == ST_IDLE && !sda_oe_out)
    else $error("stop did not return to idle");
  chk_framing_abort: assert property ((st_r == ST_TX) && stop |=> !sda_oe_out)
    else $error("read not abandoned on stop");
  chk_standby_read: assert property (stop && rd_r |=> standby_out)
    else $error("no standby after read");
  chk_bit_count: assert property (cnt_r <= `SMT_BIT_LAST)
    else $error("bit counter past eight");
  chk_ack_pulse: assert property (st_r == ST_RX && scl_fall && cnt_r == `SMT_BIT_LAST && ack_r
    && !start && !stop |=> sda_oe_out && st_r == ST_ACK)
    else $error("acknowledge not driven");
  chk_drive_on_fall: assert property ($rose(sda_oe_out) |-> $past(scl_fall))
    else $error("data line pulled outside clock fall");
  chk_busy_nack: assert property (st_r == ST_RX && scl_rise && cnt_r == `SMT_BIT_PRE &&
    byte_r == `SMT_BYTE_CMD && busy_r && !start && !stop |=> !ack_r)
    else $error("command acknowledged during write cycle");
  chk_zone_refuse: assert property (st_r == ST_RX && scl_rise && cnt_r == `SMT_BIT_PRE &&
    byte_r == `SMT_BYTE_CMD && !(cmd_in.rd ? chk_rd_ok : chk_wr_ok) && !start && !stop
    |=> !ack_r)
    else $error("zone without rights acknowledged");
  chk_write_time: assert property (blen_r <= (TMR_W+1)'(WR_CYCLES))
    else $error("write cycle too long");
  chk_low_only: assert property (sda_out == 1'b0 && (!sda_oe_out ||
    (st_r != ST_IDLE && st_r != ST_HACK)))
    else $error("data line driven high or pulled while released");
  chk_word_abandon: assert property (st_r == ST_RX && cnt_r != 4'h0 && start |=>
    cnt_r == 4'h0 && byte_r == `SMT_BYTE_CMD)
    else $error("start did not abandon the word in flight");

  cov_read_byte: cover property (st_r == ST_HACK ##1 st_r == ST_WAIT);
  cov_write_cycle: cover property ($rose(busy_r));
  cov_standby: cover property ($rose(standby_out));
  cov_busy_poll: cover property (busy_r && st_r == ST_ACK && !ack_r);
endmodule : smt_target

// ===== tb/smt_host_model.sv
// host bus controller model for the two-wire link
`timescale 1ns/1ns
module smt_host_model (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out,
  output logic res_valid_out,
  output logic [7:0] res_out
);
  initial begin
    scl_out = 1'h1;
    sda_out = 1'h1;
    res_valid_out = 1'h0;
    res_out = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : tick

  task automatic start_cond();
    sda_out = 1'h1;
    tick(2);
    scl_out = 1'h1;
    tick(4);
    sda_out = 1'h0;
    tick(4);
    scl_out = 1'h0;
    tick(2);
  endtask : start_cond

  task automatic stop_cond();
    sda_out = 1'h0;
    tick(2);
    scl_out = 1'h1;
    tick(4);
    sda_out = 1'h1;
    tick(4);
  endtask : stop_cond

  // data moves in clock low, sampled in clock high
  task automatic clk_bit(input logic b, output logic got);
    sda_out = b;
    tick(2);
    scl_out = 1'h1;
    tick(2);
    got = sda_in;
    tick(2);
    scl_out = 1'h0;
    tick(2);
  endtask : clk_bit

  // whole words, msb first, then the ninth clock
  task automatic xfer(input logic [7:0] tx, input logic rd, input logic ack_in);
    logic [7:0] rx;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(tx[i], rx[i]);
    end
    clk_bit(ack_in, a);
    res_out = rd ? rx : {7'h00, a};
    res_valid_out = 1'h1;
    tick(1);
    res_valid_out = 1'h0;
  endtask : xfer
endmodule : smt_host_model

// ===== tb/tb_top.sv
// self-checking bench for the two-wire target
`timescale 1ns/1ns
`include "smt_consts.svh"
module tb_top;
  import smt_pkg::*;
  localparam int WR_CYC = 200;
  localparam logic [7:0] ACK = 8'h00;
  localparam logic [7:0] NACK = 8'h01;
  logic clk_in = 1'h0;
  logic rst_in = 1'h1;
  logic scl, host_sda, sda_w, sda_out, sda_oe_out, busy_out, standby_out, res_valid, junk;
  logic [7:0] res, zone_rd_en, zone_wr_en;
  logic [7:0][2:0] zone_grp;
  logic [7:0] exp_q[$];
  logic [7:0] dat[4];
  logic [7:0] refused[3];
  logic oe_prev = 1'h0;
  int bad_count = 0;
  int comparisons = 0;

  always #20 clk_in = ~clk_in;
  // wired-and of the open-drain line with pull-up
  assign sda_w = host_sda & (sda_oe_out ? sda_out : 1'h1);

  smt_target #(.WR_CYCLES(WR_CYC)) DUT (.clk_in(clk_in), .rst_in(rst_in), .scl_in(scl),
    .sda_in(sda_w), .zone_rd_en_in(zone_rd_en), .zone_wr_en_in(zone_wr_en),
    .zone_grp_in(zone_grp), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .busy_out(busy_out), .standby_out(standby_out));

  smt_host_model host (.clk_in(clk_in), .sda_in(sda_w), .scl_out(scl), .sda_out(host_sda),
    .res_valid_out(res_valid), .res_out(res));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic give_verdict();
    if (bad_count == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  function automatic logic [7:0] cmd(input logic [2:0] z, input logic r);
    smt_cmd_t c;
    c.code = `SMT_CMD_CODE;
    c.zone = z;
    c.rd = r;
    return c;
  endfunction : cmd

  task automatic send(input logic [7:0] b, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.xfer(b, 1'h0, 1'h1);
  endtask : send

  task automatic recv(input logic [7:0] exp, input logic last);
    exp_q.push_back(exp);
    host.xfer(8'hff, 1'h1, last);
  endtask : recv

  task automatic wait_idle(input time t0);
    while (busy_out !== 1'h0 && $time - t0 < 40 * WR_CYC) begin
      host.tick(1);
    end
    check({7'h0, busy_out}, 8'h00, "write cycle end");
  endtask : wait_idle

  // ----------------------------------------
  // result monitor
  // ----------------------------------------
  always @(negedge clk_in) begin
    if (res_valid === 1'h1) begin
      check(res, exp_q.pop_front(), "link result");
    end
    if (!rst_in) begin
      check({7'h0, sda_oe_out === 1'h1 && sda_out !== 1'h0}, 8'h00, "line driven high");
      check({7'h0, sda_oe_out !== oe_prev && scl === 1'h1}, 8'h00, "moved in clock high");
    end
    oe_prev = sda_oe_out;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    time t0;
    void'($urandom(32'h9f73));
    zone_rd_en = 8'hef;
    zone_wr_en = 8'hfd;
    zone_grp = {3'h7, 3'h6, 3'h5, 3'h4, 3'h2, 3'h2, 3'h1, 3'h0};
    foreach (dat[i]) dat[i] = 8'($urandom);
    host.tick(16);
    rst_in = 1'h0;
    host.tick(3);
    // write across two chained zones, fifo full
    host.start_cond();
    send(cmd(3'h2, 1'h0), ACK);
    send(8'h7e, ACK);
    foreach (dat[i]) send(dat[i], ACK);
    send(8'h5a, NACK);
    host.stop_cond();
    t0 = $time;
    check({7'h0, busy_out}, 8'h01, "write cycle start");
    host.start_cond();
    send(cmd(3'h2, 1'h0), NACK);
    host.stop_cond();
    wait_idle(t0);
    host.start_cond();
    send(cmd(3'h2, 1'h1), ACK);
    send(8'h7e, ACK);
    foreach (dat[i]) recv(dat[i], i == 3);
    host.stop_cond();
    check({7'h0, standby_out}, 8'h01, "standby after read");
    // abandon a word by a new start
    host.start_cond();
    check({7'h0, standby_out}, 8'h00, "standby cleared");
    repeat (4) host.clk_bit(1'h0, junk);
    host.start_cond();
    send(cmd(3'h5, 1'h0), ACK);
    send(8'h7f, ACK);
    send(dat[0], ACK);
    send(dat[1], ACK);
    host.stop_cond();
    wait_idle($time);
    host.start_cond();
    send(cmd(3'h5, 1'h1), ACK);
    send(8'h7f, ACK);
    recv(dat[0], 1'h0);
    recv(dat[1], 1'h1);
    host.stop_cond();
    // wrong code, read right and write right refusals, then right granted
    refused[0] = {4'($urandom_range(10, 0)), 4'h0};
    refused[1] = cmd(3'h4, 1'h1);
    refused[2] = cmd(3'h1, 1'h0);
    foreach (refused[k]) begin
      host.start_cond();
      send(refused[k], NACK);
      host.stop_cond();
    end
    zone_wr_en = 8'hff;
    host.start_cond();
    send(cmd(3'h1, 1'h0), ACK);
    host.stop_cond();
    host.tick(4);
    check(8'(exp_q.size()), 8'h00, "results pending");
    give_verdict();
  end

  initial begin
    #(40 * 40000);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule : tb_top
